// file: rtl/usart_pkg.sv
// package: register map, field positions, reset values and timing counts
// assumes: a single 40 MHz bus clock; used by usart_serial_port, its checker and its testbench
package usart_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_DATA = 8'h00;
  localparam logic [7:0] OFF_CTRL = 8'h04;
  localparam logic [7:0] OFF_DIV = 8'h08;
  localparam logic [7:0] OFF_LINE_STATUS = 8'h0C;
  localparam logic [7:0] OFF_INT_STATUS = 8'h10;
  localparam logic [7:0] OFF_INT_MASK = 8'h14;
  localparam logic [7:0] OFF_FIFO_LEVEL = 8'h18;
  // control fields
  localparam int CTRL_WLEN = 0;
  localparam int CTRL_PAR_EN = 2;
  localparam int CTRL_PAR_ODD = 3;
  localparam int CTRL_STOP2 = 4;
  localparam int CTRL_MSB_FIRST = 5;
  localparam int CTRL_SYNC = 6;
  localparam int CTRL_FLOW = 7;
  localparam int CTRL_IRDA = 8;
  localparam int CTRL_RS485 = 9;
  localparam int CTRL_RX_THR = 12;
  localparam int CTRL_TOUT = 16;
  localparam logic [31:0] CTRL_RESET = 32'h0000_2001;
  // word length codes
  localparam logic [1:0] WLEN_7 = 2'h0;
  localparam logic [1:0] WLEN_8 = 2'h1;
  localparam logic [1:0] WLEN_9 = 2'h2;
  // line status fields
  localparam int LS_RX_READY = 0;
  localparam int LS_OVERRUN = 1;
  localparam int LS_PARITY = 2;
  localparam int LS_FRAMING = 3;
  localparam int LS_BREAK = 4;
  localparam int LS_TX_EMPTY = 5;
  localparam int LS_TX_IDLE = 6;
  // interrupt fields
  localparam int INT_LINE = 0;
  localparam int INT_TX_EMPTY = 1;
  localparam int INT_RX_THR = 2;
  localparam int INT_TIMEOUT = 3;
  // divider limits: async oversamples 16, sync clock half-period floor 4
  localparam logic [15:0] DIV_RESET = 16'h0001;
  localparam int OVERSAMPLE = 16;
  localparam logic [15:0] SYNC_HALF_MIN = 16'h0004;
  localparam logic [3:0] IRDA_PULSE = 4'h3;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_WIDTH = 9;
endpackage

// file: rtl/usart_serial_port.sv
// usart_serial_port: APB register slave, 8x9 fifos, async/sync serial
// engine with parity, stop bits, bit order, flow control, irda, rs485.
// assumes: apb master on ref_clk; serial inputs synchronous to ref_clk.
// Behaviour
// - character length is seven, eight or nine bits both ways.
// - parity is even, odd or absent, generated and checked.
// - the transmitter sends one or two stop bits.
// - data is shifted lsb first or msb first as configured.
// - parity, overrun and framing errors are flagged on receive.
// - the async bit clock is at most one sixteenth of ref_clk.
// - the sync serial clock is at most one eighth of ref_clk.
// - async and sync modes exist and tx and rx run at once.
// - with flow control rts shows room and tx waits while cts is off.
// - an infrared sir encoder and decoder is a selectable mode.
// - in rs485 mode an enable turns on the driver around sending.
// - tx and rx each queue eight entries of nine bits.
// - line, tx empty, rx threshold and timeout interrupts exist.
// - a line status register shows transfer state and errors.
//
// Implementation choices: the APB register port and the register addresses.
module usart_serial_port
  import usart_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial line
  output logic txd,
  input wire logic rxd,
  output logic sclk,
  output logic rts_n,
  input wire logic cts_n,
  output logic rs485_de,
  // interrupt
  output logic irq
);
  typedef enum logic [1:0] {TX_IDLE, TX_SHIFT} tx_state_e;
  typedef enum logic [1:0] {RX_IDLE, RX_SHIFT} rx_state_e;

  typedef struct packed {
    logic [31:0] ctrl;
    logic [15:0] div;
    logic [3:0] int_status;
    logic [3:0] int_mask;
    logic [4:0] line_err;
    logic [31:0] rdata;
    logic [FIFO_DEPTH-1:0][8:0] txq;
    logic [FIFO_DEPTH-1:0][8:0] rxq;
    logic [3:0] tx_cnt;
    logic [2:0] tx_rd;
    logic [3:0] rx_cnt;
    logic [2:0] rx_rd;
    tx_state_e tx_state;
    logic [15:0] tx_div;
    logic [3:0] tx_tick;
    logic [12:0] tx_shift;
    logic [3:0] tx_bits;
    logic tx_line;
    logic sclk;
    rx_state_e rx_state;
    logic [15:0] rx_div;
    logic [3:0] rx_tick;
    logic [11:0] rx_shift;
    logic [3:0] rx_bits;
    logic [4:0] low_bits;
    logic brk_seen;
    logic [7:0] idle_bits;
    logic [3:0] ir_hold;
    logic de;
  } state_s;

  state_s s_reg, s_next;

  logic wr, rd;
  logic [3:0] dlen;
  logic [3:0] frame_len;
  logic [3:0] rx_len;
  logic [8:0] wmask;
  logic rx_in;
  logic [15:0] half_div;

  assign wr = psel & penable & pwrite;
  assign rd = psel & penable & ~pwrite;
  assign pready = 1'b1;
  assign prdata = s_reg.rdata;
  assign txd = s_reg.tx_line;
  assign sclk = s_reg.sclk;
  assign rs485_de = s_reg.de;
  assign irq = |(s_reg.int_status & s_reg.int_mask);
  // rts is low (ready) while the rx queue holds fewer than seven entries
  assign rts_n = s_reg.ctrl[CTRL_FLOW] ? (s_reg.rx_cnt >= 4'(FIFO_DEPTH - 1))
                                       : 1'b0;

  // data bits per word
  always_comb begin
    case (s_reg.ctrl[CTRL_WLEN +: 2])
      WLEN_7: dlen = 4'd7;
      WLEN_9: dlen = 4'd9;
      default: dlen = 4'd8;
    endcase
  end
  assign wmask = 9'h1FF >> (4'd9 - dlen);
  // bits after start: data, parity, stop
  assign rx_len = dlen + 4'(s_reg.ctrl[CTRL_PAR_EN]) + 4'd1;
  assign frame_len = rx_len + 4'(s_reg.ctrl[CTRL_STOP2]);
  // irda receive: a short low pulse is stretched over one bit; the stretch
  // assumes a divider of one
  assign rx_in = s_reg.ctrl[CTRL_IRDA] ? (rxd && s_reg.ir_hold == 4'h0)
                                       : rxd;
  // a sync half period under four would overrun the bus clock, so it floors at four
  assign half_div = (s_reg.div < SYNC_HALF_MIN) ? SYNC_HALF_MIN
                                                : s_reg.div;

  function automatic logic [8:0] order(input logic [8:0] w,
                                       input logic [3:0] n,
                                       input logic msb);
    logic [8:0] r;
    r = 9'h000;
    for (int i = 0; i < 9; i++) begin
      if (4'(i) < n) begin
        r[i] = msb ? w[4'(n - 4'd1 - 4'(i))] : w[i];
      end
    end
    return r;
  endfunction

  always_comb begin
    logic [8:0] word;
    logic par;
    logic [8:0] rword;
    logic rpar;
    logic tick;
    word = 9'h000;
    par = 1'b0;
    rword = 9'h000;
    rpar = 1'b0;
    tick = 1'b0;
    s_next = s_reg;
    s_next.ir_hold = (s_reg.ir_hold != 4'h0) ? s_reg.ir_hold - 4'h1 : 4'h0;
    if (s_reg.ctrl[CTRL_IRDA] && !rxd) begin
      s_next.ir_hold = 4'(OVERSAMPLE - 1);
    end
    // apb register access
    if (wr) begin
      case (paddr[7:0])
        OFF_DATA: begin
          if (s_reg.tx_cnt != 4'(FIFO_DEPTH)) begin
            s_next.txq[3'(s_reg.tx_rd + s_reg.tx_cnt[2:0])] =
              pwdata[8:0] & wmask;
            s_next.tx_cnt = s_reg.tx_cnt + 4'd1;
          end
        end
        OFF_CTRL: s_next.ctrl = pwdata;
        OFF_DIV: s_next.div = (pwdata[15:0] == 16'h0000) ? DIV_RESET
                                                        : pwdata[15:0];
        OFF_INT_MASK: s_next.int_mask = pwdata[3:0];
        default: ;
      endcase
    end
    s_next.rdata = 32'h0000_0000;
    if (psel & ~penable & ~pwrite) begin
      case (paddr[7:0])
        OFF_DATA: s_next.rdata = {23'h0, s_reg.rxq[s_reg.rx_rd]};
        OFF_CTRL: s_next.rdata = s_reg.ctrl;
        OFF_DIV: s_next.rdata = {16'h0, s_reg.div};
        OFF_LINE_STATUS: s_next.rdata = {25'h0,
          s_reg.tx_state == TX_IDLE && s_reg.tx_cnt == 4'd0,
          s_reg.tx_cnt == 4'd0, s_reg.line_err[3:0],
          s_reg.rx_cnt != 4'd0};
        OFF_INT_STATUS: s_next.rdata = {28'h0, s_reg.int_status};
        OFF_INT_MASK: s_next.rdata = {28'h0, s_reg.int_mask};
        OFF_FIFO_LEVEL: s_next.rdata = {24'h0, s_reg.rx_cnt, s_reg.tx_cnt};
        default: ;
      endcase
    end
    if (rd) begin
      case (paddr[7:0])
        OFF_DATA: begin
          if (s_reg.rx_cnt != 4'd0) begin
            s_next.rx_rd = s_reg.rx_rd + 3'd1;
            s_next.rx_cnt = s_reg.rx_cnt - 4'd1;
          end
          s_next.idle_bits = 8'h00;
        end
        OFF_LINE_STATUS: s_next.line_err = 5'h00;
        OFF_INT_STATUS: s_next.int_status = 4'h0;
        default: ;
      endcase
    end

    // transmitter: 16 ticks per bit async, 2 half-periods per bit sync
    s_next.tx_div = s_reg.tx_div + 16'd1;
    if (s_reg.tx_div >= (s_reg.ctrl[CTRL_SYNC] ? half_div - 16'd1
                                               : s_reg.div - 16'd1)) begin
      s_next.tx_div = 16'h0000;
      tick = 1'b1;
    end
    case (s_reg.tx_state)
      TX_IDLE: begin
        s_next.tx_line = 1'b1;
        s_next.sclk = 1'b1;
        s_next.de = 1'b0;
        if (s_reg.tx_cnt != 4'd0 &&
            !(s_reg.ctrl[CTRL_FLOW] && cts_n)) begin
          word = order(s_reg.txq[s_reg.tx_rd], dlen,
                       s_reg.ctrl[CTRL_MSB_FIRST]);
          par = ^(s_reg.txq[s_reg.tx_rd] & wmask) ^
                s_reg.ctrl[CTRL_PAR_ODD];
          s_next.tx_shift = 13'h1FFF;
          // unused upper bits must read as stop level
          s_next.tx_shift[8:0] = word | ~wmask;
          s_next.tx_shift[12] = 1'b0;
          if (s_reg.ctrl[CTRL_PAR_EN]) begin
            s_next.tx_shift[dlen] = par;
          end
          s_next.tx_rd = s_reg.tx_rd + 3'd1;
          s_next.tx_cnt = s_next.tx_cnt - 4'd1;
          s_next.tx_bits = frame_len;
          s_next.tx_tick = 4'h0;
          s_next.tx_div = 16'h0000;
          // start bit async; irda keeps the line high until its pulse
          s_next.tx_line = s_reg.ctrl[CTRL_SYNC] | s_reg.ctrl[CTRL_IRDA];
          s_next.de = s_reg.ctrl[CTRL_RS485];
          s_next.tx_state = TX_SHIFT;
          if (s_reg.ctrl[CTRL_SYNC]) begin
            s_next.tx_line = word[0];
            s_next.tx_shift = {1'b1, s_next.tx_shift[12:1]};
            s_next.tx_bits = dlen;
          end
          if (s_next.tx_cnt == 4'd0) begin
            s_next.int_status[INT_TX_EMPTY] = 1'b1;
          end
        end
      end
      TX_SHIFT: begin
        if (tick) begin
          s_next.tx_tick = s_reg.tx_tick + 4'd1;
          if (s_reg.ctrl[CTRL_SYNC]) begin
            s_next.sclk = ~s_reg.sclk;
            if (!s_reg.sclk) begin
              s_next.tx_line = s_reg.tx_shift[0];
              s_next.tx_shift = {1'b1, s_reg.tx_shift[12:1]};
              s_next.tx_bits = s_reg.tx_bits - 4'd1;
              if (s_reg.tx_bits == 4'd1) begin
                s_next.tx_state = TX_IDLE;
              end
            end
          end else begin
            if (s_reg.tx_tick == 4'(OVERSAMPLE - 1)) begin
              s_next.tx_line = s_reg.tx_shift[0];
              s_next.tx_shift = {1'b1, s_reg.tx_shift[12:1]};
              s_next.tx_shift[12] = s_reg.tx_shift[0];
              s_next.tx_bits = s_reg.tx_bits - 4'd1;
              if (s_reg.tx_bits == 4'd0) begin
                s_next.tx_line = 1'b1;
                s_next.tx_state = TX_IDLE;
              end
            end
            // after the bit boundary, so no raw level glitches out
            if (s_reg.ctrl[CTRL_IRDA]) begin
              s_next.tx_line = ~(s_reg.tx_tick >= 4'h7 &&
                s_reg.tx_tick < 4'h7 + IRDA_PULSE && !s_reg.tx_shift[12]);
            end
          end
        end
      end
      default: s_next.tx_state = TX_IDLE;
    endcase

    // receiver: async, samples mid-bit at tick 8
    s_next.rx_div = s_reg.rx_div + 16'd1;
    if (s_reg.rx_div >= s_reg.div - 16'd1) begin
      s_next.rx_div = 16'h0000;
      s_next.rx_tick = s_reg.rx_tick + 4'd1;
      if (s_reg.rx_tick == 4'(OVERSAMPLE - 1)) begin
        // bit period boundary: break and timeout tracking
        s_next.low_bits = rx_in ? 5'd0 : s_reg.low_bits + 5'd1;
        if (s_reg.low_bits > 5'(frame_len) && !s_reg.brk_seen) begin
          s_next.line_err[LS_BREAK - 1] = 1'b1;
          s_next.brk_seen = 1'b1;
          s_next.int_status[INT_LINE] = 1'b1;
        end
        if (rx_in) begin
          s_next.brk_seen = 1'b0;
        end
        if (s_reg.rx_cnt != 4'd0 && s_reg.idle_bits != 8'hFF) begin
          s_next.idle_bits = s_reg.idle_bits + 8'd1;
          if (s_reg.idle_bits + 8'd1 == s_reg.ctrl[CTRL_TOUT +: 8]) begin
            s_next.int_status[INT_TIMEOUT] = 1'b1;
          end
        end
      end
      case (s_reg.rx_state)
        RX_IDLE: begin
          if (!rx_in && !s_reg.brk_seen) begin
            s_next.rx_state = RX_SHIFT;
            s_next.rx_tick = 4'h1;
            s_next.rx_bits = 4'd0;
            s_next.rx_shift = 12'h000;
          end
        end
        RX_SHIFT: begin
          if (s_reg.rx_tick == 4'h8) begin
            if (s_reg.rx_bits == 4'd0 && rx_in) begin
              s_next.rx_state = RX_IDLE; // false start
            end else if (s_reg.rx_bits != 4'd0) begin
              s_next.rx_shift[4'(s_reg.rx_bits - 4'd1)] = rx_in;
            end
            s_next.rx_bits = s_reg.rx_bits + 4'd1;
            if (s_reg.rx_bits == rx_len) begin
              s_next.rx_state = RX_IDLE;
              rword = order(s_reg.rx_shift[8:0] & wmask, dlen,
                            s_reg.ctrl[CTRL_MSB_FIRST]);
              rpar = s_reg.rx_shift[dlen];
              s_next.idle_bits = 8'h00;
              if (s_reg.ctrl[CTRL_PAR_EN] &&
                  (^rword ^ s_reg.ctrl[CTRL_PAR_ODD]) != rpar) begin
                s_next.line_err[LS_PARITY - 1] = 1'b1;
                s_next.int_status[INT_LINE] = 1'b1;
              end
              if (!rx_in) begin
                s_next.line_err[LS_FRAMING - 1] = 1'b1;
                s_next.int_status[INT_LINE] = 1'b1;
              end
              if (s_next.rx_cnt == 4'(FIFO_DEPTH)) begin
                s_next.line_err[LS_OVERRUN - 1] = 1'b1;
                s_next.int_status[INT_LINE] = 1'b1;
              end else begin
                s_next.rxq[3'(s_next.rx_rd + s_next.rx_cnt[2:0])] =
                  rword;
                s_next.rx_cnt = s_next.rx_cnt + 4'd1;
                if (s_next.rx_cnt == s_reg.ctrl[CTRL_RX_THR +: 4]) begin
                  s_next.int_status[INT_RX_THR] = 1'b1;
                end
              end
            end
          end
        end
        default: s_next.rx_state = RX_IDLE;
      endcase
    end
  end

  assign pslverr = 1'b0;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
      s_reg.ctrl <= CTRL_RESET;
      s_reg.div <= DIV_RESET;
      s_reg.tx_line <= 1'b1;
      s_reg.sclk <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule

// file: testbench/usart_serial_port_chk.sv
// checker: port-level timing relations of usart_serial_port
// assumes: bound to the design; divider left at its reset value
module usart_serial_port_chk
  import usart_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // line and interrupt
  input wire logic txd,
  input wire logic rxd,
  input wire logic sclk,
  input wire logic rts_n,
  input wire logic cts_n,
  input wire logic rs485_de,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] ctrl_q;
  logic [7:0] lo_cnt;
  logic [7:0] run;
  logic sclk_d;
  logic rd_acc;
  assign rd_acc = psel && penable && !pwrite;
  // shadow of the control word, so mode-gated checks follow software
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= CTRL_RESET;
      lo_cnt <= 8'h00;
      run <= 8'hFF;
      sclk_d <= 1'b1;
    end else begin
      if (psel && penable && pwrite && paddr[7:0] == OFF_CTRL) begin
        ctrl_q <= pwdata;
      end
      lo_cnt <= txd ? 8'h00 : lo_cnt + 8'h01;
      sclk_d <= sclk;
      run <= (sclk != sclk_d) ? 8'h01 : (run == 8'hFF ? run : run + 8'h01);
    end
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  a_ready_now:
    assert property (psel |-> pready && !pslverr)
    else $error("apb transfer not answered at once");
  a_unmapped_zero:
    assert property (rd_acc && paddr[7:0] == 8'h1C |-> prdata == 32'h0)
    else $error("unmapped read returned data");
  a_fifo_bound:
    assert property (rd_acc && paddr[7:0] == OFF_FIFO_LEVEL
      |-> prdata[7:4] <= 4'h8 && prdata[3:0] <= 4'h8)
    else $error("queue level above eight");
  a_bit_length:
    assert property ($rose(txd) && !ctrl_q[CTRL_SYNC] && !ctrl_q[CTRL_IRDA]
      |-> lo_cnt != 8'h00 && lo_cnt[3:0] == 4'h0)
    else $error("low run not whole sixteen-cycle bits");
  a_ir_pulse:
    assert property ($rose(txd) && ctrl_q[CTRL_IRDA] && !ctrl_q[CTRL_SYNC]
      |-> lo_cnt == 8'h03)
    else $error("infrared pulse not three cycles");
  a_sclk_half:
    assert property (sclk != sclk_d |-> run >= 8'h04)
    else $error("serial clock half period below four");
  a_cts_hold:
    assert property (ctrl_q[CTRL_FLOW] && !ctrl_q[CTRL_SYNC] && cts_n
      && $past(cts_n) && $past(cts_n, 2) |-> !$fell(txd))
    else $error("frame started while remote refused");
  a_de_around:
    assert property ($fell(txd) && ctrl_q[CTRL_RS485]
      |-> ##[0:1] rs485_de [*8])
    else $error("driver enable off during frame");
  a_irq_masked:
    assert property (psel && penable && pwrite && paddr[7:0] == OFF_INT_MASK
      && pwdata == 32'h0 |-> ##2 !irq)
    else $error("interrupt high with all masked");
endmodule
bind usart_serial_port usart_serial_port_chk i_chk (.ref_clk(ref_clk),
  .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .txd(txd), .rxd(rxd), .sclk(sclk), .rts_n(rts_n),
  .cts_n(cts_n), .rs485_de(rs485_de), .irq(irq));

// file: testbench/remote_serial.sv
// remote_serial: far serial device, sends and catches raw bit frames
// assumes: one bit is BIT ref_clk cycles; caller builds the frame
module remote_serial #(
  parameter int BIT = 16
) (
  // clock
  input wire logic ref_clk,
  // line
  input wire logic txd,
  input wire logic rts_n,
  output logic rxd,
  output logic cts_n
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    rxd = 1'b1;
    cts_n = 1'b0;
  end
  task automatic set_cts_n(input logic v);
    @(posedge ref_clk);
    cts_n <= v;
  endtask
  task automatic send(input logic [31:0] f, input int n, output bit ok);
    int k;
    k = 0;
    while (rts_n !== 1'b0 && k < 4000) begin
      @(posedge ref_clk);
      k++;
    end
    ok = (k < 4000);
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk);
      rxd <= f[i];
      repeat (BIT - 1) @(posedge ref_clk);
    end
    @(posedge ref_clk);
    rxd <= 1'b1;
  endtask
  // infrared: a zero bit is a three-cycle low pulse inside its bit
  task automatic send_ir(input logic [31:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      repeat (7) @(posedge ref_clk);
      rxd <= f[i];
      repeat (3) @(posedge ref_clk);
      rxd <= 1'b1;
      repeat (6) @(posedge ref_clk);
    end
  endtask
  // samples mid-bit, so a cycle of slack at the start edge is harmless
  task automatic capture(input int n, output logic [31:0] f, output bit ok);
    int k;
    f = '0;
    k = 0;
    while (txd !== 1'b0 && k < 2000) begin
      @(posedge ref_clk);
      k++;
    end
    ok = (k < 2000);
    repeat (BIT / 2) @(posedge ref_clk);
    for (int i = 0; i < n; i++) begin
      f[i] = txd;
      repeat (BIT) @(posedge ref_clk);
    end
  endtask
endmodule

// file: testbench/usart_serial_port_tb.sv
// testbench: apb driver, frame model and checks for usart_serial_port
// assumes: remote_serial on the line, checker bound in its own file
module usart_serial_port_tb
  import usart_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, seed = 32'hE4407BCA;
  logic pready, pslverr, txd, rxd, sclk, rts_n, cts_n, rs485_de, irq;
  int error_cnt = 0, checks = 0;
  logic [31:0] cfg [6] = '{32'h1000, 32'h1005, 32'h102E, 32'h101D,
    32'h1201, 32'h1081};
  always #12.5 ref_clk = ~ref_clk;
  usart_serial_port i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .txd(txd),
    .rxd(rxd), .sclk(sclk), .rts_n(rts_n), .cts_n(cts_n),
    .rs485_de(rs485_de), .irq(irq));
  remote_serial #(.BIT(OVERSAMPLE)) i_far (.ref_clk(ref_clk), .txd(txd),
    .rts_n(rts_n), .rxd(rxd), .cts_n(cts_n));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_frame(input logic [31:0] got, exp, input int n);
    chk_word(got & ((32'h1 << n) - 32'h1), exp & ((32'h1 << n) - 32'h1));
  endtask
  task automatic chk_done(input bit ok);
    if (!ok) begin
      error_cnt++;
      $display("mismatch at %0t: wait ran out", $time);
      wrap_up();
    end
  endtask
  // read right after the edge: these are the values the slave showed at it
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r);
    int k;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {4'h0, a};
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    chk_done(k < 20);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    apb(1'b0, a, 32'h0, r);
  endtask
  // whole frame on the wire, index 0 first: start, data, parity, stops
  function automatic void mk(input logic [31:0] c, input logic [8:0] d,
    output logic [31:0] f, output int n);
    int w;
    logic p;
    w = 7 + int'(c[1:0]);
    p = c[CTRL_PAR_ODD];
    f = 32'hFFFF_FFFE;
    n = 1;
    for (int i = 0; i < w; i++) begin
      f[n] = c[CTRL_MSB_FIRST] ? d[w - 1 - i] : d[i];
      p ^= f[n];
      n++;
    end
    if (c[CTRL_PAR_EN]) begin
      f[n] = p;
      n++;
    end
    n += c[CTRL_STOP2] ? 2 : 1;
  endfunction
  initial begin
    repeat (100000) @(posedge ref_clk);
    chk_done(1'b0);
  end
  initial begin
    logic [31:0] r, f, got, c;
    int n;
    bit ok, ok2;
    logic [8:0] q [$];
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(OFF_CTRL, r);
    chk_word(r, CTRL_RESET);
    rd(OFF_DIV, r);
    chk_word(r, {16'h0000, DIV_RESET});
    wr(8'h1C, 32'hFFFF_FFFF);
    rd(8'h1C, r);
    chk_word(r, 32'h0);
    rd(OFF_LINE_STATUS, r);
    chk_word(r & 32'h7F, 32'h60);
    $display("test reset done");
    foreach (cfg[i]) begin
      c = cfg[i];
      r = rnd();
      wr(OFF_CTRL, c);
      mk(c, r[8:0], f, n);
      i_far.set_cts_n(c[CTRL_FLOW]);
      wr(OFF_DATA, r & 32'h1FF);
      if (c[CTRL_FLOW]) begin
        repeat (300) @(posedge ref_clk);
        chk_word({31'h0, txd}, 32'h1);
        i_far.set_cts_n(1'b0);
      end
      fork
        i_far.capture(n, got, ok);
        i_far.send(f, n, ok2);
      join
      chk_done(ok && ok2);
      chk_frame(got, f, n);
      c = (32'h1 << (7 + int'(c[1:0]))) - 32'h1;
      rd(OFF_DATA, got);
      chk_word(got & 32'h1FF, r & c);
      rd(OFF_LINE_STATUS, got);
      chk_word(got & 32'h1E, 32'h0);
      if (cfg[i][CTRL_RS485]) chk_word({31'h0, rs485_de}, 32'h0);
      $display("test frame %0d done", i);
    end
    wr(OFF_CTRL, 32'h1105);
    r = rnd();
    mk(32'h1105, r[8:0], f, n);
    wr(OFF_DATA, r & 32'h1FF);
    i_far.send_ir(f, n);
    repeat (40) @(posedge ref_clk);
    rd(OFF_DATA, got);
    chk_word(got & 32'h1FF, r & 32'hFF);
    $display("test infrared done");
    wr(OFF_CTRL, 32'h1005);
    wr(OFF_INT_MASK, 32'h1);
    for (int k = 0; k < 3; k++) begin
      mk(32'h1005, 9'h0A5, f, n);
      if (k == 0) f[9] = ~f[9];
      if (k == 1) f[10] = 1'b0;
      if (k == 2) f = 32'h0;
      if (k == 2) n = 24;
      i_far.send(f, n, ok);
      chk_done(ok);
      repeat (4) @(posedge ref_clk);
      chk_word({31'h0, irq}, 32'h1);
      rd(OFF_LINE_STATUS, r);
      chk_word(r & (32'h4 << k), 32'h4 << k);
      rd(OFF_INT_STATUS, r);
      chk_word(r & 32'h1, 32'h1);
      repeat (2) @(posedge ref_clk);
      chk_word({31'h0, irq}, 32'h0);
      $display("test fault %0d done", k);
    end
    wr(OFF_INT_MASK, 32'h0);
    repeat (9) rd(OFF_DATA, r);
    for (int k = 0; k < 9; k++) begin
      r = rnd();
      mk(32'h1005, r[8:0], f, n);
      if (k < 8) q.push_back({1'b0, r[7:0]});
      i_far.send(f, n, ok);
      chk_done(ok);
    end
    rd(OFF_FIFO_LEVEL, r);
    chk_word(r & 32'hF0, 32'h80);
    wr(OFF_CTRL, 32'h1085);
    @(posedge ref_clk);
    chk_word({31'h0, rts_n}, 32'h1);
    rd(OFF_LINE_STATUS, r);
    chk_word(r & 32'h2, 32'h2);
    while (q.size() > 0) begin
      rd(OFF_DATA, r);
      chk_word(r & 32'h1FF, {23'h0, q.pop_front()});
    end
    @(posedge ref_clk);
    chk_word({31'h0, rts_n}, 32'h0);
    $display("test overrun done");
    // sync runs last: its data timing is not the async bit grid
    wr(OFF_CTRL, 32'h1041);
    wr(OFF_DATA, 32'h1FF);
    repeat (200) @(posedge ref_clk);
    chk_word({31'h0, sclk}, 32'h1);
    $display("test sync done");
    wrap_up();
  end
endmodule
